/* hw/caf_filter.sv */
// Acceptance filter: 14 banks, Wishbone slave, match index search
//
// Functional notes
// - Fourteen filter banks, 13 to 0, each active one checked against each identifier.
// - Each bank owns two software-writable 32-bit words.
// - Wide scale: one 32-bit filter over std, ext, IDE, RTR.
// - Narrow scale: two 16-bit filters over std, RTR, IDE, ext[17:15].
// - Mask mode compares only bits marked must-match by the mask.
// - List mode uses mask positions as further identifiers.
// - List mode accepts only on exact equality of every bit.
// - Per-bank scale bit in the scale register selects 32 or 16 bit.
// - Per-bank style bit selects list or mask mode.
// - Filters in a bank numbered from zero; one, two or four.
// - Accepted message carries index of accepting filter by priority.
// - Index numbering counts filters of inactive banks too.
// - Separate index sequence for each receive FIFO.
// - Message matched by no filter is dropped silently.
// - Priority: wide over narrow, list over mask, lowest number.
// - Accepted message goes to the matching filter's FIFO with index.
// - Match index sits in its field of the length and stamp word.
`timescale 1ns/10ps
`include "caf_params.svh"
module caf_filter #(
  parameter int NBANK = `CAF_NBANK
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Received frame identifier
  input  wire logic                rx_valid_i,
  input  wire caf_pkg::caf_rx_id_s rx_id_i,
  // Accepted frame towards the receive FIFOs
  output logic                     acc_valid_o,
  output caf_pkg::caf_acc_s        acc_o,
  output logic      [31:0]         acc_stamp_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = dat[8*i +: 8];
    end
    return r;
  endfunction
  function automatic logic [2:0] filt_count(input logic wide, input logic list);
    return wide ? (list ? 3'd2 : 3'd1) : (list ? 3'd4 : 3'd2);
  endfunction
  function automatic logic sub_hit(input logic [31:0] w, input logic [15:0] h, input logic [31:0] r1,
                                   input logic [31:0] r2, input logic wide, input logic list, input int k);
    logic [15:0] hi1;
    logic [15:0] hi2;
    hi1 = r1[`CAF_HALF_MASK_LSB +: 16];
    hi2 = r2[`CAF_HALF_MASK_LSB +: 16];
    if (wide && list)
      return (k == 0) ? (w == r1) : (w == r2);
    if (wide)
      return ((w ^ r1) & r2) == 32'h0000_0000;
    if (list)
      case (k)
        0: return h == r1[15:0];
        1: return h == hi1;
        2: return h == r2[15:0];
        default: return h == hi2;
      endcase
    return (k == 0) ? (((h ^ r1[15:0]) & hi1) == 16'h0000)
                    : (((h ^ r2[15:0]) & hi2) == 16'h0000);
  endfunction
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]      w1_q [NBANK];
  logic [31:0]      w1_d [NBANK];
  logic [31:0]      w2_q [NBANK];
  logic [31:0]      w2_d [NBANK];
  logic [NBANK-1:0] act_q;
  logic [NBANK-1:0] act_d;
  logic [NBANK-1:0] scale_q;
  logic [NBANK-1:0] scale_d;
  logic [NBANK-1:0] style_q;
  logic [NBANK-1:0] style_d;
  logic [NBANK-1:0] fifo_q;
  logic [NBANK-1:0] fifo_d;
  logic             init_q;
  logic             init_d;
  logic [9:0]       last_q;
  logic [9:0]       last_d;
  logic             ack_q;
  logic             ack_d;
  logic [31:0]      rdat_q;
  logic [31:0]      rdat_d;
  logic             req;
  logic             wr;
  logic [3:0]       bsel;
  assign req      = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr       = req && wb_we_i;
  assign bsel     = wb_adr_i[6:3];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  always_comb
  begin
    w1_d    = w1_q;
    w2_d    = w2_q;
    act_d   = act_q;
    scale_d = scale_q;
    style_d = style_q;
    fifo_d  = fifo_q;
    init_d  = init_q;
    rdat_d  = 32'h0000_0000;
    ack_d   = req;
    if (wb_adr_i < `CAF_BANK_END)
    begin
      if (wr && !wb_adr_i[2])
        w1_d[bsel] = wb_merge(w1_q[bsel], wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i[2])
        w2_d[bsel] = wb_merge(w2_q[bsel], wb_dat_i, wb_sel_i);
      rdat_d = wb_adr_i[2] ? w2_q[bsel] : w1_q[bsel];
    end
    else
    begin
      if (wr && (wb_adr_i == `CAF_ACT_OFS))
        act_d = NBANK'(wb_merge(32'(act_q), wb_dat_i, wb_sel_i));
      if (wr && (wb_adr_i == `CAF_SCALE_OFS))
        scale_d = NBANK'(wb_merge(32'(scale_q), wb_dat_i, wb_sel_i));
      if (wr && (wb_adr_i == `CAF_STYLE_OFS))
        style_d = NBANK'(wb_merge(32'(style_q), wb_dat_i, wb_sel_i));
      if (wr && (wb_adr_i == `CAF_FIFO_OFS))
        fifo_d = NBANK'(wb_merge(32'(fifo_q), wb_dat_i, wb_sel_i));
      if (wr && (wb_adr_i == `CAF_MASTER_OFS) && wb_sel_i[0])
        init_d = wb_dat_i[0];
      unique case (wb_adr_i)
        `CAF_ACT_OFS:    rdat_d = 32'(act_q);
        `CAF_SCALE_OFS:  rdat_d = 32'(scale_q);
        `CAF_STYLE_OFS:  rdat_d = 32'(style_q);
        `CAF_FIFO_OFS:   rdat_d = 32'(fifo_q);
        `CAF_MASTER_OFS: rdat_d = 32'(init_q);
        `CAF_LAST_OFS:   rdat_d = 32'(last_q);
        default:         rdat_d = 32'h0000_0000;
      endcase
    end
    if (!req)
      rdat_d = rdat_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int b = 0; b < NBANK; b++)
      begin
        w1_q[b] <= `CAF_WORD_RST;
        w2_q[b] <= `CAF_WORD_RST;
      end
      act_q   <= `CAF_CFG_RST;
      scale_q <= `CAF_CFG_RST;
      style_q <= `CAF_CFG_RST;
      fifo_q  <= `CAF_CFG_RST;
      init_q  <= `CAF_MASTER_RST;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end
    else
    begin
      w1_q    <= w1_d;
      w2_q    <= w2_d;
      act_q   <= act_d;
      scale_q <= scale_d;
      style_q <= style_d;
      fifo_q  <= fifo_d;
      init_q  <= init_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Match search
  // ----------------------------------------------------------------
  logic [31:0] wide_w;
  logic [15:0] half_w;
  logic        found;
  logic [1:0]  best_rank;
  logic [7:0]  best_fmi;
  logic        best_fifo;
  logic [3:0]  best_bank;
  assign wide_w = {rx_id_i.std_id, rx_id_i.ext_id, rx_id_i.ide, rx_id_i.rtr, 1'b0};
  assign half_w = {rx_id_i.std_id, rx_id_i.rtr, rx_id_i.ide, rx_id_i.ext_id[17:15]};

  always_comb
  begin
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic [7:0] base;
    logic [7:0] filter_match_index;
    logic [1:0] rank;
    cnt0      = 8'h00;
    cnt1      = 8'h00;
    base      = 8'h00;
    filter_match_index       = 8'h00;
    rank      = 2'h0;
    found     = 1'b0;
    best_rank = 2'h0;
    best_fmi  = 8'h00;
    best_fifo = 1'b0;
    best_bank = 4'h0;
    for (int b = 0; b < NBANK; b++)
    begin
      base = fifo_q[b] ? cnt1 : cnt0;
      rank = {scale_q[b], style_q[b]};
      for (int k = 0; k < 4; k++)
      begin
        filter_match_index = base + 8'(k);
        if (act_q[b] && (3'(k) < filt_count(scale_q[b], style_q[b])) &&
            sub_hit(wide_w, half_w, w1_q[b], w2_q[b], scale_q[b], style_q[b], k))
        begin
          if (!found || (rank > best_rank) || ((rank == best_rank) && (filter_match_index < best_fmi)))
          begin
            found     = 1'b1;
            best_rank = rank;
            best_fmi  = filter_match_index;
            best_fifo = fifo_q[b];
            best_bank = 4'(b);
          end
        end
      end
      if (fifo_q[b])
        cnt1 = cnt1 + 8'(filt_count(scale_q[b], style_q[b]));
      else
        cnt0 = cnt0 + 8'(filt_count(scale_q[b], style_q[b]));
    end
  end

  // ----------------------------------------------------------------
  // Accept output
  // ----------------------------------------------------------------
  logic                acc_valid_q;
  logic                acc_valid_d;
  caf_pkg::caf_acc_s   acc_q;
  caf_pkg::caf_acc_s   acc_d;
  logic [3:0]          win_bank_q;
  logic [3:0]          win_bank_d;
  logic                win_wide_q;
  logic                win_wide_d;
  logic                take;
  assign take        = rx_valid_i && found && !init_q;
  assign acc_valid_o = acc_valid_q;
  assign acc_o       = acc_q;
  assign acc_stamp_o = {16'h0000, acc_q.filter_match_index, 8'h00};

  always_comb
  begin
    acc_valid_d = take;
    acc_d       = acc_q;
    win_bank_d  = win_bank_q;
    win_wide_d  = win_wide_q;
    last_d      = last_q;
    if (take)
    begin
      acc_d.fifo = best_fifo;
      acc_d.filter_match_index  = best_fmi;
      acc_d.id   = rx_id_i;
      win_bank_d = best_bank;
      win_wide_d = best_rank[1];
      last_d     = {1'b1, best_fifo, best_fmi};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_valid_q <= 1'b0;
      acc_q       <= '0;
      win_bank_q  <= 4'h0;
      win_wide_q  <= 1'b0;
      last_q      <= 10'h000;
    end
    else
    begin
      acc_valid_q <= acc_valid_d;
      acc_q       <= acc_d;
      win_bank_q  <= win_bank_d;
      win_wide_q  <= win_wide_d;
      last_q      <= last_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ACCEPT_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_i && found && !init_q |=> acc_valid_o && acc_o.filter_match_index == $past(best_fmi))
    else $error("accepted frame not delivered next cycle");
  AST_DROP_SILENT: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_i && !found |=> !acc_valid_o && $stable(last_q))
    else $error("unmatched frame was not dropped silently");
  AST_BANK_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_o |-> win_bank_q < 4'(NBANK) && act_q[win_bank_q])
    else $error("winning bank out of range or inactive");
  AST_FIFO_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_o |-> acc_o.fifo == fifo_q[win_bank_q])
    else $error("frame routed to wrong fifo");
  AST_WIDE_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_i && !init_q && act_q[NBANK-1] && scale_q[NBANK-1] && style_q[NBANK-1] && wide_w == w1_q[NBANK-1]
    |=> acc_valid_o && win_wide_q)
    else $error("wide filter lost priority");
  AST_LIST_EXACT: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_o && win_wide_q && style_q[win_bank_q]
    |-> ({acc_o.id, 1'b0} == w1_q[win_bank_q]) || ({acc_o.id, 1'b0} == w2_q[win_bank_q]))
    else $error("wide list acceptance without exact identifier match");
  AST_SCALE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == `CAF_SCALE_OFS && wb_sel_i[0] |=> scale_q[0] == $past(wb_dat_i[0]))
    else $error("scale bit write lost");
  AST_STYLE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == `CAF_STYLE_OFS && wb_sel_i[0] |=> style_q[1] == $past(wb_dat_i[1]))
    else $error("style bit write lost");
  AST_WORD_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == 8'h04 && wb_sel_i == 4'hf |=> w2_q[0] == $past(wb_dat_i) ##1 wb_ack_o == 1'b0)
    else $error("bank word write lost or ack too long");
  AST_FMI_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_o |-> acc_o.filter_match_index < 8'(4 * NBANK))
    else $error("match index out of range");
endmodule

/* hw/caf_params.svh */
// Register map, field positions and sizes of the acceptance filter
`ifndef CAF_PARAMS_SVH
`define CAF_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define CAF_NBANK        14
`define CAF_FMI_W        8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CAF_BANK_END     8'h70
`define CAF_ACT_OFS      8'h80
`define CAF_SCALE_OFS    8'h84
`define CAF_STYLE_OFS    8'h88
`define CAF_FIFO_OFS     8'h8c
`define CAF_MASTER_OFS   8'h90
`define CAF_LAST_OFS     8'h94

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define CAF_CFG_RST      14'h0000
`define CAF_WORD_RST     32'h0000_0000
`define CAF_MASTER_RST   1'b1
`define CAF_HALF_MASK_LSB 16
`define CAF_STAMP_FMI_LSB 8
`define CAF_LAST_FIFO_BIT 8
`define CAF_LAST_SEEN_BIT 9

`endif

/* hw/caf_pkg.sv */
// Types shared by the acceptance filter and its users
package caf_pkg;

  typedef struct packed {
    logic [10:0] std_id;
    logic [17:0] ext_id;
    logic        ide;
    logic        rtr;
  } caf_rx_id_s;

  typedef struct packed {
    logic       fifo;
    logic [7:0] filter_match_index;
    caf_rx_id_s id;
  } caf_acc_s;

endpackage

/* bench/caf_rx_model.sv */
// Behavioural model of the receive logic that hands identifiers to the filter
`timescale 1ns/10ps
module caf_rx_model (
  // Clock
  input  wire logic           clk_i,
  // Identifier stream
  output logic                rx_valid_o,
  output caf_pkg::caf_rx_id_s rx_id_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_id_o    = '0;
  end
  // One frame per call; identifier scrambled once no frame is offered
  task automatic send(input caf_pkg::caf_rx_id_s id);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o    <= id;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o    <= ~id;
  endtask
endmodule

/* bench/caf_filter_tb_top.sv */
// Self-checking bench for the acceptance filter
`timescale 1ns/10ps
`include "caf_params.svh"
module caf_filter_tb_top;
  typedef struct packed {
    caf_pkg::caf_rx_id_s id;
    logic                hit;
    logic                fifo;
    logic [7:0]          filter_match_index;
  } caf_row_s;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i = 1'b0;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [3:0]          wb_sel_i = 4'h0;
  logic [31:0]         wb_dat_i = 32'h0000_0000;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic                rx_valid_i;
  caf_pkg::caf_rx_id_s rx_id_i;
  logic                acc_valid_o;
  caf_pkg::caf_acc_s   acc_o;
  logic [31:0]         acc_stamp_o;
  int                  error_cnt = 0;
  int                  check_count = 0;
  int                  cycles = 0;
  logic                lf = 1'b0;
  logic [7:0]          lm = 8'h00;
  caf_pkg::caf_rx_id_s lid = '0;
  logic [31:0]         q;
  caf_row_s            rows[14];

  caf_filter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i),
    .acc_valid_o(acc_valid_o), .acc_o(acc_o), .acc_stamp_o(acc_stamp_o));
  caf_rx_model rx (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i));

  // ----------------------------------------------------------------
  // Clock, timeout, reporting
  // ----------------------------------------------------------------
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      test_done;
    end
  end
  task automatic test_done;
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and frame helpers
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    chk("wb_lat", n, 2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(nm, q, e);
  endtask
  function automatic logic [31:0] fw(input logic [10:0] s, input logic [17:0] e, input logic i, input logic r);
    return {s, e, i, r, 1'b0};
  endfunction
  function automatic logic [15:0] fh(input logic [10:0] s);
    return {s, 5'h00};
  endfunction
  function automatic caf_row_s mk(input logic [10:0] s, input logic [17:0] e, input logic i, input logic r,
                                  input logic h, input logic f, input logic [7:0] m);
    return '{'{s, e, i, r}, h, f, m};
  endfunction
  task automatic frame(input caf_row_s r);
    rx.send(r.id);
    #1;
    chk("acc_valid", acc_valid_o, r.hit);
    if (r.hit)
    begin
      lf = r.fifo;
      lm = r.filter_match_index;
      lid = r.id;
    end
    chk("acc", acc_o, {lf, lm, lid});
    chk("stamp", acc_stamp_o, {16'h0000, lm, 8'h00});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (15) @(posedge clk_i);
    #1;
    chk("rst_out", {acc_valid_o, wb_ack_o, acc_stamp_o}, '0);
    chk("rst_acc", acc_o, '0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("master", `CAF_MASTER_OFS, 32'h0000_0001);
    rdc("act_rst", `CAF_ACT_OFS, 32'h0000_0000);
    wr(`CAF_ACT_OFS, 32'h0000_0000);
    wr(8'h00, {16'hff00, fh(11'h300)});
    wr(8'h04, {16'hffff, fh(11'h400)});
    wr(8'h08, fw(11'h123, 18'h00000, 1'b0, 1'b0));
    wr(8'h0c, fw(11'h124, 18'h00000, 1'b0, 1'b0));
    wr(8'h10, fw(11'h123, 18'h00000, 1'b0, 1'b0));
    wr(8'h14, fw(11'h7ff, 18'h00000, 1'b0, 1'b0));
    wr(8'h18, {2{fh(11'h500)}});
    wr(8'h1c, {2{fh(11'h500)}});
    wr(8'h20, {fh(11'h601), fh(11'h600)});
    wr(8'h24, {fh(11'h603), fh(11'h602)});
    wr(8'h68, fw(11'h305, 18'h00000, 1'b0, 1'b0));
    wr(8'h6c, fw(11'h7ff, 18'h3ffff, 1'b1, 1'b1));
    wr(`CAF_SCALE_OFS, 32'h0000_2006);
    wr(`CAF_STYLE_OFS, 32'h0000_201a);
    wr(`CAF_FIFO_OFS, 32'h0000_001c);
    wr(`CAF_ACT_OFS, 32'hffff_e017);
    rdc("act", `CAF_ACT_OFS, 32'h0000_2017);
    rdc("scale", `CAF_SCALE_OFS, 32'h0000_2006);
    rdc("word", 8'h20, {fh(11'h601), fh(11'h600)});
    wb(1'b1, 8'h28, 32'hffff_ffff, 4'b0010);
    rdc("sel", 8'h28, 32'h0000_ff00);
    wb(1'b1, 8'h98, 32'hffff_ffff, 4'hf);
    rdc("unmapped", 8'h98, 32'h0000_0000);
    frame(mk(11'h123, 18'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'd0));
    wr(`CAF_MASTER_OFS, 32'h0000_0000);
    rows = '{mk(11'h123, 18'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'd2),
             mk(11'h124, 18'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'd3),
             mk(11'h123, 18'h0, 1'b0, 1'b1, 1'b1, 1'b1, 8'd0),
             mk(11'h301, 18'h3ffff, 1'b1, 1'b1, 1'b1, 1'b0, 8'd0),
             mk(11'h305, 18'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'd20),
             mk(11'h7ff, 18'h3ffff, 1'b1, 1'b1, 1'b1, 1'b0, 8'd21),
             mk(11'h400, 18'h07fff, 1'b0, 1'b0, 1'b1, 1'b0, 8'd1),
             mk(11'h400, 18'h08000, 1'b0, 1'b0, 1'b0, 1'b0, 8'd0),
             mk(11'h500, 18'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'd0),
             mk(11'h600, 18'h0, 1'b0, 1'b0, 1'b1, 1'b1, 8'd5),
             mk(11'h601, 18'h0, 1'b0, 1'b0, 1'b1, 1'b1, 8'd6),
             mk(11'h602, 18'h0, 1'b0, 1'b0, 1'b1, 1'b1, 8'd7),
             mk(11'h603, 18'h0, 1'b0, 1'b0, 1'b1, 1'b1, 8'd8),
             mk(11'h7fe, 18'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'd0)};
    foreach (rows[i])
      frame(rows[i]);
    rdc("last", `CAF_LAST_OFS, 32'h0000_0308);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("rerst_acc", acc_o, '0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("re_master", `CAF_MASTER_OFS, 32'h0000_0001);
    lf = 1'b0;
    lm = 8'h00;
    lid = '0;
    frame(mk(11'h600, 18'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'd0));
    test_done;
  end
endmodule
